// *** core/rom_flash_window_decode.sv ***
// Purpose: Window decode and write filter for two boot ROM/Flash blocks
// Assumes: Wishbone classic register slave, one-cycle access requests
// Notes: Answers come one cycle after the request
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
module rom_flash_window_decode (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic local_rst_i,
    input wire logic ce_i,
    // Strap pins
    input wire logic [3:0] strap_pin_i,
    // Wishbone register slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Processor bus access
    input wire logic acc_req_i,
    input wire logic acc_we_i,
    input wire logic [31:0] acc_addr_i,
    input wire logic [5:0] acc_size_i,
    // Access answer
    output logic acc_ack_o,
    output logic acc_sel_a_o,
    output logic acc_sel_b_o,
    output logic acc_wr_o,
    output logic acc_wide_o,
    output logic [25:0] acc_offset_o
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [11:0] base_q [2];
    logic [2:0] siz_q [2];
    logic [1:0] en_q;
    logic [1:0] wen_q;
    logic [1:0] vec_q;
    logic [1:0] wide_q;
    logic [3:0] strap_m_q;
    logic [3:0] strap_q;
    logic [1:0] win_match;
    logic [1:0] reg_hit;
    logic wb_go;
    logic wb_ack_q;
    logic [31:0] wb_dat_q;
    logic [31:0] rd_word;
    logic top_hit;
    logic top_a;
    logic top_b;
    logic hit_a;
    logic hit_b;
    logic sel_wide;
    logic sel_wen;
    logic [2:0] sel_siz;
    logic size_ok;
    logic resp;
    logic dev_wr;
    logic [25:0] offset_d;
    logic ack_q;
    logic sel_a_q;
    logic sel_b_q;
    logic wr_q;
    logic wide_q_o;
    logic [25:0] offset_q;

    // ------------------------------------------------------------
    // Strap synchroniser
    // ------------------------------------------------------------

    // Two flops before the straps are used
    always_ff @(posedge clk_i) begin
        if (ce_i || rst_i) begin
            strap_m_q <= strap_pin_i;
            strap_q <= strap_m_q;
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------

    // Address decode of the two window registers
    always_comb begin
        reg_hit[rom_win_pkg::BLK_A] = (wb_adr_i == rom_win_pkg::A_WIN_ADDR);
        reg_hit[rom_win_pkg::BLK_B] = (wb_adr_i == rom_win_pkg::B_WIN_ADDR);
        wb_go = wb_cyc_i && wb_stb_i && !wb_ack_q;
    end

    // Read word of the addressed register, unmapped reads zero
    always_comb begin
        rd_word = 32'h0000_0000;
        for (int i = 0; i < 2; i++) begin
            if (reg_hit[i]) begin
                rd_word[31:rom_win_pkg::BASE_LSB] = base_q[i];
                rd_word[rom_win_pkg::WIDE_BIT] = wide_q[i];
                rd_word[rom_win_pkg::SIZ_LSB +: 3] = siz_q[i];
                rd_word[rom_win_pkg::VEC_BIT] = vec_q[i];
                rd_word[rom_win_pkg::EN_BIT] = en_q[i];
                rd_word[rom_win_pkg::WE_BIT] = wen_q[i];
            end
        end
    end

    // Ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_q <= wb_go;
            if (wb_go && !wb_we_i) begin
                wb_dat_q <= rd_word;
            end
        end
    end

    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = wb_dat_q;

    // ------------------------------------------------------------
    // Window registers
    // ------------------------------------------------------------

    // Base, size, enable and write enable; set to their reset values by either reset
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (rst_i || local_rst_i) begin
                base_q[i] <= (i == 0) ? rom_win_pkg::A_BASE_RST
                                      : rom_win_pkg::B_BASE_RST;
                siz_q[i] <= rom_win_pkg::SIZ_RST;
                en_q[i] <= 1'b0;
                wen_q[i] <= 1'b0;
            end else if (ce_i && wb_go && wb_we_i && reg_hit[i]) begin
                if (wb_sel_i[3]) begin
                    base_q[i][11:4] <= wb_dat_i[31:24];
                end
                if (wb_sel_i[2]) begin
                    base_q[i][3:0] <= wb_dat_i[23:20];
                    siz_q[i] <= wb_dat_i[rom_win_pkg::SIZ_LSB +: 3];
                end
                if (wb_sel_i[0]) begin
                    en_q[i] <= wb_dat_i[rom_win_pkg::EN_BIT];
                    wen_q[i] <= wb_dat_i[rom_win_pkg::WE_BIT];
                end
            end
        end
    end

    // Vector and width bits take the straps at power-up only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vec_q <= strap_q[1:0];
            wide_q <= strap_q[3:2];
        end else if (ce_i && wb_go && wb_we_i && wb_sel_i[0]) begin
            for (int i = 0; i < 2; i++) begin
                if (reg_hit[i]) begin
                    vec_q[i] <= wb_dat_i[rom_win_pkg::VEC_BIT];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Window matchers
    // ------------------------------------------------------------

    // One matcher per block
    for (genvar g = 0; g < 2; g++) begin : g_win
        window_if w ();
        assign w.base = base_q[g];
        assign w.siz = siz_q[g];
        assign w.en = en_q[g];
        assign w.addr_hi = acc_addr_i[31:20];
        assign win_match[g] = w.match;
        window_match u_match (
            .w (w.win)
        );
    end

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------

    // Top megabyte goes to the vector source, B winning there; elsewhere A wins over B
    always_comb begin
        top_hit = (acc_addr_i[31:20] == rom_win_pkg::TOP_MB);
        top_b = top_hit && vec_q[rom_win_pkg::BLK_B];
        top_a = top_hit && vec_q[rom_win_pkg::BLK_A]
            && !vec_q[rom_win_pkg::BLK_B];
        hit_a = top_a || (!top_hit && win_match[rom_win_pkg::BLK_A]);
        hit_b = top_b || (!top_hit && win_match[rom_win_pkg::BLK_B]
            && !win_match[rom_win_pkg::BLK_A]);
    end

    // Setup of the chosen block
    always_comb begin
        sel_wide = hit_b ? wide_q[rom_win_pkg::BLK_B] : wide_q[rom_win_pkg::BLK_A];
        sel_wen = hit_b ? wen_q[rom_win_pkg::BLK_B] : wen_q[rom_win_pkg::BLK_A];
        sel_siz = hit_b ? siz_q[rom_win_pkg::BLK_B] : siz_q[rom_win_pkg::BLK_A];
    end

    // Narrow takes single bytes, wide takes aligned words
    always_comb begin
        if (sel_wide) begin
            size_ok = (acc_size_i == rom_win_pkg::XFER_WORD)
                && (acc_addr_i[1:0] == 2'h0);
        end else begin
            size_ok = (acc_size_i == rom_win_pkg::XFER_BYTE);
        end
    end

    // Reads of a hit block always answer; bad writes get no answer
    always_comb begin
        resp = (hit_a || hit_b) && (!acc_we_i || size_ok);
        dev_wr = resp && acc_we_i && sel_wen;
    end

    // Offset inside the block; top range maps the first megabyte
    always_comb begin
        offset_d = {acc_addr_i[25:20] & ~(6'h3f << sel_siz), acc_addr_i[19:0]};
        if (top_a || top_b) begin
            offset_d[25:20] = 6'h00;
        end
    end

    // ------------------------------------------------------------
    // Access answer registers
    // ------------------------------------------------------------

    // One-cycle answer pulse after each request that hits a block and passes the write check
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            sel_a_q <= 1'b0;
            sel_b_q <= 1'b0;
            wr_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= acc_req_i && resp;
            sel_a_q <= acc_req_i && resp && hit_a;
            sel_b_q <= acc_req_i && resp && hit_b;
            wr_q <= acc_req_i && dev_wr;
        end
    end

    // Data of the answer, held until the next request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wide_q_o <= 1'b0;
            offset_q <= 26'h000_0000;
        end else if (ce_i && acc_req_i) begin
            wide_q_o <= sel_wide;
            offset_q <= offset_d;
        end
    end

    assign acc_ack_o = ack_q;
    assign acc_sel_a_o = sel_a_q;
    assign acc_sel_b_o = sel_b_q;
    assign acc_wr_o = wr_q;
    assign acc_wide_o = wide_q_o;
    assign acc_offset_o = offset_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    logic rd_req;
    assign rd_req = ce_i && acc_req_i && !acc_we_i;

    chk_base_match: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_req && !top_hit && en_q[0] && siz_q[0] == 3'h0
            && acc_addr_i[31:20] == base_q[0]
        |=> acc_ack_o && acc_sel_a_o)
        else $error("block A window base not matched");

    chk_size_ignore: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_req && !top_hit && en_q[0] && siz_q[0] == 3'h2
            && acc_addr_i[31:22] == base_q[0][11:2]
        |=> acc_sel_a_o && acc_offset_o[21:20] == $past(acc_addr_i[21:20]))
        else $error("size did not mask low base bits");

    chk_base_reset: assert property (
        @(posedge clk_i) disable iff (rst_i)
        local_rst_i |=> base_q[0] == 12'hff0 && base_q[1] == 12'hff4)
        else $error("base not reloaded by local reset");

    chk_size_rsvd: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_req && !top_hit && siz_q[0] == 3'h7
        |=> !acc_sel_a_o)
        else $error("reserved size code answered");

    chk_top_b: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_req && top_hit && vec_q[1]
        |=> acc_sel_b_o && !acc_sel_a_o && acc_offset_o[25:20] == 6'h00)
        else $error("top range not served by block B");

    chk_top_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_req && top_hit && vec_q[0] && !vec_q[1]
        |=> acc_sel_a_o && acc_offset_o[19:0] == $past(acc_addr_i[19:0]))
        else $error("top range not served by block A");

    chk_top_none: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && acc_req_i && top_hit && vec_q == 2'b00 |=> !acc_ack_o)
        else $error("top range answered with no vector source");

    chk_strap_load: assert property (
        @(posedge clk_i)
        rst_i ##1 !rst_i |-> vec_q == $past(strap_q[1:0], 1))
        else $error("vector bits not taken from straps");

    chk_wide_fixed: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(!rst_i) |-> $stable(wide_q))
        else $error("width bit changed after reset");

    chk_en_gate: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && acc_req_i && !top_hit && en_q == 2'b00 |=> !acc_ack_o)
        else $error("disabled window answered");

    chk_narrow_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && acc_req_i && acc_we_i && !sel_wide
            && acc_size_i != 6'h01 |=> !acc_ack_o)
        else $error("narrow block took a multi-byte write");

    chk_misaligned: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && acc_req_i && acc_we_i && acc_addr_i[1:0] != 2'h0
            && acc_size_i == 6'h04 |=> !acc_ack_o)
        else $error("misaligned word write answered");

    chk_wr_protect: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && acc_req_i && acc_we_i && (hit_a || hit_b) && size_ok
            && !sel_wen |=> acc_ack_o && !acc_wr_o)
        else $error("protected write not ended cleanly");

    chk_read_ack: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_req && (hit_a || hit_b) |=> acc_ack_o && !acc_wr_o)
        else $error("read of enabled window not answered");

    cov_top_read: cover property (
        @(posedge clk_i) disable iff (rst_i)
        rd_req && top_b ##1 acc_ack_o);

    cov_write_done: cover property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && acc_req_i && dev_wr ##1 acc_wr_o);

    cov_write_refused: cover property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && acc_req_i && acc_we_i && (hit_a || hit_b) && !size_ok);

    cov_reg_write: cover property (
        @(posedge clk_i) disable iff (rst_i)
        wb_go && wb_we_i && reg_hit[1] ##1 wb_ack_o);
endmodule : rom_flash_window_decode

// *** core/rom_win_pkg.sv ***
// Purpose: Shared constants for the boot block window decoder
// Assumes: Big-endian bit 0 of the register is the word's bit 31
// Notes: Register word layout is base, width, size, then vector/enable/write bits
package rom_win_pkg;
    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] A_WIN_ADDR = 32'hfef80050;
    localparam logic [31:0] B_WIN_ADDR = 32'hfef80058;

    // ------------------------------------------------------------
    // Field positions in the window register
    // ------------------------------------------------------------
    localparam int BASE_LSB = 20;
    localparam int WIDE_BIT = 19;
    localparam int SIZ_LSB = 16;
    localparam int VEC_BIT = 2;
    localparam int EN_BIT = 1;
    localparam int WE_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [11:0] A_BASE_RST = 12'hff0;
    localparam logic [11:0] B_BASE_RST = 12'hff4;
    localparam logic [2:0] SIZ_RST = 3'h0;

    // ------------------------------------------------------------
    // Decode constants
    // ------------------------------------------------------------
    localparam logic [11:0] TOP_MB = 12'hfff;
    localparam logic [2:0] SIZ_RSVD = 3'h7;
    localparam logic [5:0] XFER_BYTE = 6'h01;
    localparam logic [5:0] XFER_WORD = 6'h04;

    // Block index of the register array
    typedef enum logic [0:0] {
        BLK_A = 1'b0,
        BLK_B = 1'b1
    } blk_t;
endpackage : rom_win_pkg

// *** core/window_if.sv ***
// Purpose: Carries one block's window setup and its match answer
// Assumes: Driven by the decoder top, answered by window_match
// Notes: Purely combinational signals
`timescale 1ns/1ps
interface window_if;
    logic [11:0] base;
    logic [2:0] siz;
    logic en;
    logic [11:0] addr_hi;
    logic match;

    modport cfg (output base, output siz, output en, output addr_hi, input match);
    modport win (input base, input siz, input en, input addr_hi, output match);
endinterface : window_if

// *** core/window_match.sv ***
// Purpose: Matches the top twelve address bits against one block window
// Assumes: Size code steps the window from 1 MB to 64 MB
// Notes: Reserved size code never matches
`timescale 1ns/1ps
module window_match (
    // Window setup and answer
    window_if.win w
);
    logic [11:0] keep_mask;

    // ------------------------------------------------------------
    // Base compare
    // ------------------------------------------------------------

    // Low base bits covered by the size are dropped from the compare
    always_comb begin
        keep_mask = 12'hfff << w.siz;
        w.match = w.en && (w.siz != rom_win_pkg::SIZ_RSVD)
            && (((w.addr_hi ^ w.base) & keep_mask) == 12'h000);
    end
endmodule : window_match

// *** dv/acc_master_model.sv ***
// Purpose: Processor bus master that issues accesses to the window decoder
// Assumes: One request pulse per access; an answer comes one cycle later or never
// Notes: Released request lines show the inverse of their last value
`timescale 1ns/1ps
module acc_master_model (
    // Clock
    input wire logic clk_i,
    // Request
    output logic acc_req_o,
    output logic acc_we_o,
    output logic [31:0] acc_addr_o,
    output logic [5:0] acc_size_o,
    // Answer
    input wire logic acc_ack_i
);
    // Idle request lines at time zero
    initial begin
        acc_req_o = 1'b0;
        acc_we_o = 1'b0;
        acc_addr_o = 32'h0;
        acc_size_o = 6'h0;
    end

    // One access; ack tells whether it was terminated normally
    task automatic access(input logic we, input logic [31:0] addr, input logic [5:0] size,
                          output logic ack);
        @(posedge clk_i);
        acc_req_o <= 1'b1;
        acc_we_o <= we;
        acc_addr_o <= addr;
        acc_size_o <= size;
        @(posedge clk_i);
        acc_req_o <= 1'b0;
        acc_we_o <= ~we;
        acc_addr_o <= ~addr;
        acc_size_o <= ~size;
        #1;
        ack = acc_ack_i;
    endtask : access
endmodule : acc_master_model

// *** dv/test_rom_flash_window_decode.sv ***
// Purpose: Self-checking bench for the boot block window decoder
// Assumes: Register answers and access answers come one cycle after the request
// Notes: Windows are placed away from the top megabyte and from each other
`timescale 1ns/1ps
module test_rom_flash_window_decode;
    localparam logic [31:0] RA = rom_win_pkg::A_WIN_ADDR;
    localparam logic [31:0] RB = rom_win_pkg::B_WIN_ADDR;
    localparam logic [5:0] BAD_SZ [7] = '{6'h02, 6'h03, 6'h05, 6'h06, 6'h07, 6'h08, 6'h20};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic local_rst_i = 1'b0;
    logic ce_i = 1'b1;
    logic [3:0] strap_pin_i = 4'h6;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_ack_o, acc_req_i, acc_we_i, acc_ack_o, acc_sel_a_o, acc_sel_b_o, acc_wr_o;
    logic acc_wide_o;
    logic [31:0] acc_addr_i;
    logic [5:0] acc_size_i;
    logic [25:0] acc_offset_o;
    int error_cnt = 0;
    int checks = 0;

    rom_flash_window_decode uut (.clk_i(clk_i), .rst_i(rst_i), .local_rst_i(local_rst_i),
        .ce_i(ce_i), .strap_pin_i(strap_pin_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .acc_req_i(acc_req_i),
        .acc_we_i(acc_we_i), .acc_addr_i(acc_addr_i), .acc_size_i(acc_size_i),
        .acc_ack_o(acc_ack_o), .acc_sel_a_o(acc_sel_a_o), .acc_sel_b_o(acc_sel_b_o),
        .acc_wr_o(acc_wr_o), .acc_wide_o(acc_wide_o), .acc_offset_o(acc_offset_o));
    acc_master_model bus (.clk_i(clk_i), .acc_req_o(acc_req_i), .acc_we_o(acc_we_i),
        .acc_addr_o(acc_addr_i), .acc_size_o(acc_size_i), .acc_ack_i(acc_ack_o));

    // Clock of 10 ns
    always #5 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report();
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // Classic single cycle; holds the request until ack is sampled
    task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                           output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n == 20) chk(32'h0, 32'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb_xfer

    // Window write wrapped in a quiet envelope of register reads
    task automatic cfg(input logic [31:0] adr, input logic [31:0] dat);
        logic [31:0] v;
        repeat (2) wb_xfer(1'b0, 32'hfef80000, 32'h0, v);
        wb_xfer(1'b1, adr, dat, v);
        repeat (2) wb_xfer(1'b0, 32'hfef80000, 32'h0, v);
    endtask : cfg

    // One access; exp is ack, select A, select B, write
    task automatic acc(input logic we, input logic [31:0] a, input logic [5:0] sz,
                       input logic [3:0] exp);
        logic k;
        bus.access(we, a, sz, k);
        chk({28'h0, k, acc_sel_a_o, acc_sel_b_o, acc_wr_o}, {28'h0, exp});
    endtask : acc

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset(input logic [3:0] s, input logic [31:0] ea, input logic [31:0] eb);
        logic [31:0] v;
        @(posedge clk_i);
        rst_i <= 1'b1;
        strap_pin_i <= s;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_xfer(1'b0, RA, 32'h0, v);
        chk(v, ea);
        wb_xfer(1'b0, RB, 32'h0, v);
        chk(v, eb);
        wb_xfer(1'b0, 32'hfef80054, 32'h0, v);
        chk(v, 32'h0);
    endtask : t_reset

    task automatic t_regs();
        logic [31:0] v;
        cfg(RA, 32'h12320007);
        wb_xfer(1'b0, RA, 32'h0, v);
        chk(v, 32'h123a0007);
        cfg(RB, 32'h456b0002);
        wb_xfer(1'b0, RB, 32'h0, v);
        chk(v, 32'h45630002);
    endtask : t_regs

    // Low base bits set on purpose: they must be ignored; windows stay clear of others
    task automatic t_window();
        logic [11:0] b;
        int m;
        for (int c = 0; c < 8; c++) begin
            m = (c < 7) ? (1 << c) : 0;
            b = 12'h400 + 12'((1 << c) - 1);
            cfg(RA, {b, 1'b0, c[2:0], 13'h0, 3'b011});
            acc(1'b0, 32'h40000000, 6'h08, (c < 7) ? 4'hc : 4'h0);
            if (c < 7) begin
                acc(1'b0, {12'h400 + 12'(m - 1), 20'hfffff}, 6'h01, 4'hc);
                chk({6'h0, acc_offset_o}, ((m - 1) << 20) | 32'hfffff);
                chk({31'h0, acc_wide_o}, 32'h1);
                acc(1'b0, {12'h400 + 12'(m), 20'h0}, 6'h04, 4'h0);
            end
        end
        cfg(RA, 32'h40000001);
        acc(1'b0, 32'h40000000, 6'h04, 4'h0);
    endtask : t_window

    task automatic t_vector();
        for (int v = 0; v < 4; v++) begin
            cfg(RA, {12'h400, 4'h0, 13'h0, v[0], 2'b10});
            cfg(RB, {12'h800, 4'h0, 13'h0, v[1], 2'b10});
            acc(1'b0, 32'hfff12345, 6'h04, v[1] ? 4'ha : (v[0] ? 4'hc : 4'h0));
            if (v != 0) chk({6'h0, acc_offset_o}, 32'h00012345);
        end
    endtask : t_vector

    // Block A is wide and block B narrow after the second power-up reset
    task automatic t_writes();
        for (int w = 0; w < 2; w++) begin
            cfg(RA, {12'h400, 4'h0, 13'h0, 2'b01, w[0]});
            cfg(RB, {12'h800, 4'h0, 13'h0, 2'b01, w[0]});
            acc(1'b1, 32'h40000010, 6'h04, {3'b110, w[0]});
            chk({31'h0, acc_wide_o}, 32'h1);
            acc(1'b1, 32'h40000012, 6'h04, 4'h0);
            acc(1'b1, 32'h40000013, 6'h01, 4'h0);
            acc(1'b1, 32'h80000013, 6'h01, {3'b101, w[0]});
            chk({31'h0, acc_wide_o}, 32'h0);
            acc(1'b1, 32'h80000010, 6'h04, 4'h0);
            acc(1'b0, 32'h80000011, 6'h02, 4'ha);
            foreach (BAD_SZ[i]) begin
                acc(1'b1, 32'h40000010, BAD_SZ[i], 4'h0);
                acc(1'b1, 32'h80000010, BAD_SZ[i], 4'h0);
            end
        end
    endtask : t_writes

    // Clock enable low freezes the answer path; block A is still enabled here
    task automatic t_freeze();
        @(posedge clk_i);
        ce_i <= 1'b0;
        acc(1'b0, 32'h40000000, 6'h04, 4'h0);
        @(posedge clk_i);
        ce_i <= 1'b1;
        acc(1'b0, 32'h40000000, 6'h04, 4'hc);
    endtask : t_freeze

    task automatic t_local();
        logic [31:0] v;
        cfg(RA, 32'h12330007);
        @(posedge clk_i);
        local_rst_i <= 1'b1;
        @(posedge clk_i);
        local_rst_i <= 1'b0;
        wb_xfer(1'b0, RA, 32'h0, v);
        chk(v, 32'hff080004);
        wb_xfer(1'b0, RB, 32'h0, v);
        chk(v, 32'hff400000);
        acc(1'b0, 32'hff000000, 6'h04, 4'h0);
    endtask : t_local

    // Main sequence
    initial begin
        t_reset(4'h9, 32'hff000004, 32'hff480000);
        t_reset(4'h6, 32'hff080000, 32'hff400004);
        t_regs();
        t_window();
        t_vector();
        t_writes();
        t_freeze();
        t_local();
        final_report();
    end

    // Watchdog against a hang
    initial begin
        #300000;
        error_cnt++;
        final_report();
    end
endmodule : test_rom_flash_window_decode
